// *** hw/pmc_ctl_if.sv ***
// pmc_ctl_if: write strobes and flag state between the control top and its two banks.
// assumes all parties on the same clock; strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
interface pmc_ctl_if;
    logic       wr_set;
    logic       wr_clr;
    logic       wr_ovf_clr;
    logic [2:0] wbits;
    logic [2:0] ovf_set;
    logic [2:0] en_q;
    logic [2:0] ovf_q;

    modport ctrl (output wr_set, output wr_clr, output wr_ovf_clr, output wbits,
                  output ovf_set, input en_q, input ovf_q);
    modport enb  (input wr_set, input wr_clr, input wbits, output en_q);
    modport ovf  (input wr_ovf_clr, input wbits, input ovf_set, output ovf_q);
endinterface
`default_nettype wire

// *** hw/pmc_ctrl.sv ***
// pmc_ctrl: enable, overflow, software-increment and selection control for two event
// counters and one cycle counter, reached by coprocessor accesses and the debug bus.
// assumes the core, the debug bus and the counter datapaths all run on clk.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE_01] enable word: cycle enable bit 31, event enables bits 1 and 0, rest zero
// [RULE_02] enable-set read shows one for each enabled counter
// [RULE_03] enable-set write of one enables that counter, zero leaves it
// [RULE_04] enable-clear has the same layout and reads the current enables
// [RULE_05] enable-clear write of one disables that counter, zero leaves it
// [RULE_06] global switch low stops every counter regardless of its own enable
// [RULE_07] individual enables keep their values while the global switch is low
// [RULE_08] overflow word: cycle flag bit 31, event flags bits 1 and 0, rest zero
// [RULE_09] overflow read shows one for each counter that wrapped since cleared
// [RULE_10] overflow write of one clears that flag, zero leaves it
// [RULE_11] software increment is write-only; ones bump event counter 1 or 0 once
// [RULE_12] software increment only affects counters whose event type is zero
// [RULE_13] selection holds five bits: 0, 1 pick counters, 31 picks the filter
// [RULE_14] software avoids event type access while selection holds 31
// [RULE_15] software writes only 0, 1 or 31 into the selection field
// [RULE_16] coprocessor 9/12 with op2 one to five reach the five registers
// [RULE_17] one copy of each register, no split by security state
// [RULE_18] unprivileged access needs the user enable; privileged always allowed
// [RULE_19] set, clear, overflow and increment also sit on the debug bus
// [RULE_20] global switch high lets counters follow their enables; resets low
// [RULE_21] event type zero counts software increments only, never hardware events
// [RULE_22] a wrap of an enabled counter sets its sticky overflow flag
// [RULE_23] enables and flags reset to zero; writes arrive one per cycle
module pmc_ctrl
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // coprocessor access from the core
    input  wire logic        cp_req,
    input  wire logic        cp_write,
    input  wire logic [2:0]  cp_opc1,
    input  wire logic [3:0]  cp_crn,
    input  wire logic [3:0]  cp_crm,
    input  wire logic [2:0]  cp_opc2,
    input  wire logic [31:0] cp_wdata,
    input  wire logic        cp_priv,
    input  wire logic        user_access_en,
    output logic             cp_done,
    output logic             cp_undef,
    output logic [31:0]      cp_rdata,
    // debug APB port
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [12:0] debug_bus_address,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // counter datapaths
    input  wire logic [7:0]  evt_type0,
    input  wire logic [7:0]  evt_type1,
    input  wire logic [1:0]  hw_event,
    input  wire logic [2:0]  cnt_wrap,
    output logic [2:0]       cnt_inc,
    output logic [2:0]       cnt_active,
    output logic [4:0]       counter_select,
    output logic             global_count_en
);

    pmc_ctl_if cbus ();

    logic        global_ff;
    logic [4:0]  sel_ff;
    logic [2:0]  inc_ff;
    logic [2:0]  active_ff;
    logic        cp_done_ff;
    logic        cp_undef_ff;
    logic [31:0] cp_rdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;

    // coprocessor decode
    wire         cp_coord;
    wire [5:0]   cp_hit;
    wire         cp_allowed;
    wire         cp_go;

    assign cp_coord = (cp_opc1 == pmc_pkg::CP_OPC1)
                      && (cp_crn == pmc_pkg::CP_CRN)
                      && (cp_crm == pmc_pkg::CP_CRM);
    assign cp_hit[pmc_pkg::HIT_CTRL]   = cp_coord && (cp_opc2 == pmc_pkg::OP2_CTRL);
    assign cp_hit[pmc_pkg::HIT_EN_SET] = cp_coord && (cp_opc2 == pmc_pkg::OP2_EN_SET); // [RULE_16]
    assign cp_hit[pmc_pkg::HIT_EN_CLR] = cp_coord && (cp_opc2 == pmc_pkg::OP2_EN_CLR); // [RULE_16]
    assign cp_hit[pmc_pkg::HIT_OVF]    = cp_coord && (cp_opc2 == pmc_pkg::OP2_OVF);    // [RULE_16]
    assign cp_hit[pmc_pkg::HIT_SWINC]  = cp_coord && (cp_opc2 == pmc_pkg::OP2_SWINC);  // [RULE_16]
    assign cp_hit[pmc_pkg::HIT_SEL]    = cp_coord && (cp_opc2 == pmc_pkg::OP2_SEL);    // [RULE_16]

    // no security input at all: secure and non-secure reach the same flops
    assign cp_allowed = cp_priv | user_access_en;                                      // [RULE_18]
    assign cp_go      = cp_req & cp_allowed & (|cp_hit);                               // [RULE_17]

    // debug bus decode; word aligned, bit 12 selects the monitor space
    wire         dbg_space;
    wire [5:0]   apb_hit;
    wire         apb_go;

    assign dbg_space = debug_bus_address[pmc_pkg::DBG_SPACE];
    assign apb_hit[pmc_pkg::HIT_CTRL]   = 1'b0;
    assign apb_hit[pmc_pkg::HIT_EN_SET] = dbg_space
        && (debug_bus_address[12:2] == pmc_pkg::APB_EN_SET[12:2]);                     // [RULE_19]
    assign apb_hit[pmc_pkg::HIT_EN_CLR] = dbg_space
        && (debug_bus_address[12:2] == pmc_pkg::APB_EN_CLR[12:2]);                     // [RULE_19]
    assign apb_hit[pmc_pkg::HIT_OVF]    = dbg_space
        && (debug_bus_address[12:2] == pmc_pkg::APB_OVF[12:2]);                        // [RULE_19]
    assign apb_hit[pmc_pkg::HIT_SWINC]  = dbg_space
        && (debug_bus_address[12:2] == pmc_pkg::APB_SWINC[12:2]);                      // [RULE_19]
    assign apb_hit[pmc_pkg::HIT_SEL]    = 1'b0;

    // the core wins a shared cycle; the debug transfer just waits one more cycle,
    // so only one writer ever reaches the banks
    assign apb_go = psel & penable & ~pready_ff & ~cp_req;                             // [RULE_23]

    // merged access
    wire [5:0]   acc_hit;
    wire         acc_wr;
    wire [31:0]  acc_wdata;
    wire [5:0]   wr_hit;
    wire [5:0]   rd_hit;

    assign acc_hit   = cp_go ? cp_hit : (apb_go ? apb_hit : 6'h00);
    assign acc_wr    = cp_go ? cp_write : (apb_go & pwrite);
    assign acc_wdata = cp_go ? cp_wdata : pwdata;
    assign wr_hit    = acc_hit & {pmc_pkg::NHIT{acc_wr}};
    assign rd_hit    = acc_hit & {pmc_pkg::NHIT{~acc_wr}};

    // bank strobes; reserved bits of the written word are simply never looked at
    assign cbus.wbits      = pmc_pkg::pmc_unpack(acc_wdata);                           // [RULE_01]
    assign cbus.wr_set     = wr_hit[pmc_pkg::HIT_EN_SET];                              // [RULE_03]
    assign cbus.wr_clr     = wr_hit[pmc_pkg::HIT_EN_CLR];                              // [RULE_05]
    assign cbus.wr_ovf_clr = wr_hit[pmc_pkg::HIT_OVF];                                 // [RULE_10]
    // wrap only counts while the counter is really running
    assign cbus.ovf_set    = cnt_wrap & active_ff;                                     // [RULE_22]

    pmc_enable_bank u_enable
    (
        .clk  (clk),
        .nrst (nrst),
        .bus  (cbus.enb)
    );

    pmc_ovf_bank u_ovf
    (
        .clk  (clk),
        .nrst (nrst),
        .bus  (cbus.ovf)
    );

    // control enable bit and selection field
    wire         nxt_global;
    wire [4:0]   nxt_sel;

    assign nxt_global = wr_hit[pmc_pkg::HIT_CTRL] ? acc_wdata[pmc_pkg::CTRL_EN_BIT]
                                                   : global_ff;                        // [RULE_20]
    // every 5-bit value is stored; only 0, 1 and 31 mean anything downstream
    assign nxt_sel    = wr_hit[pmc_pkg::HIT_SEL] ? acc_wdata[4:0] : sel_ff;            // [RULE_13]

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            global_ff <= pmc_pkg::RST_GLOBAL;                                          // [RULE_20]
        else
            global_ff <= nxt_global;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            sel_ff <= pmc_pkg::RST_SEL;
        else
            sel_ff <= nxt_sel;
    end

    // effective counting: the stored enables are masked, never altered
    wire [2:0]   nxt_active;
    wire [1:0]   swinc_bits;
    wire [1:0]   type_is_sw;
    wire [2:0]   nxt_inc;

    assign nxt_active = cbus.en_q & {pmc_pkg::NSLOT{global_ff}};                       // [RULE_06]
    assign swinc_bits = {acc_wdata[pmc_pkg::BIT_EV1], acc_wdata[pmc_pkg::BIT_EV0]}
                        & {2{wr_hit[pmc_pkg::HIT_SWINC]}};                             // [RULE_11]
    assign type_is_sw[0] = (evt_type0 == pmc_pkg::EVT_SWINC);
    assign type_is_sw[1] = (evt_type1 == pmc_pkg::EVT_SWINC);

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_evt
            // type zero takes software pulses only, other types hardware events only
            assign nxt_inc[g] = nxt_active[g]                                          // [RULE_07]
                                & (type_is_sw[g] ? swinc_bits[g] : hw_event[g]);       // [RULE_12] [RULE_21]
        end
    endgenerate
    assign nxt_inc[pmc_pkg::SLOT_CYC] = nxt_active[pmc_pkg::SLOT_CYC];

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            active_ff <= 3'h0;
        else
            active_ff <= nxt_active;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            inc_ff <= 3'h0;
        else
            inc_ff <= nxt_inc;
    end

    // read word; the increment register is write-only and reads zero
    wire [31:0]  en_word;
    wire [31:0]  ovf_word;
    wire [31:0]  ctrl_word;
    wire [31:0]  sel_word;
    wire [31:0]  rd_word;

    assign en_word   = pmc_pkg::pmc_pack(cbus.en_q);                                   // [RULE_02] [RULE_04]
    assign ovf_word  = pmc_pkg::pmc_pack(cbus.ovf_q);                                  // [RULE_08] [RULE_09]
    assign ctrl_word = {31'h0000_0000, global_ff};
    assign sel_word  = {27'h000_0000, sel_ff};                                         // [RULE_13]
    assign rd_word   = ({32{rd_hit[pmc_pkg::HIT_CTRL]}}   & ctrl_word)
                     | ({32{rd_hit[pmc_pkg::HIT_EN_SET]}} & en_word)                   // [RULE_02]
                     | ({32{rd_hit[pmc_pkg::HIT_EN_CLR]}} & en_word)                   // [RULE_04]
                     | ({32{rd_hit[pmc_pkg::HIT_OVF]}}    & ovf_word)                  // [RULE_09]
                     | ({32{rd_hit[pmc_pkg::HIT_SEL]}}    & sel_word);                 // [RULE_13]

    // core answer: every request answered one cycle later
    wire         nxt_cp_undef;
    wire [31:0]  nxt_cp_rdata;

    assign nxt_cp_undef = cp_req & ~cp_go;                                             // [RULE_18]
    assign nxt_cp_rdata = (cp_go & ~cp_write) ? rd_word : 32'h0000_0000;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cp_done_ff  <= 1'b0;
            cp_undef_ff <= 1'b0;
            cp_rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            cp_done_ff  <= cp_req;
            cp_undef_ff <= nxt_cp_undef;
            cp_rdata_ff <= nxt_cp_rdata;
        end
    end

    // debug answer: one wait state, error for anything outside the four words
    wire         nxt_pslverr;
    wire [31:0]  nxt_prdata;

    assign nxt_pslverr = apb_go & ~(|apb_hit);
    assign nxt_prdata  = (apb_go & ~pwrite) ? rd_word : 32'h0000_0000;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
        else
        begin
            pready_ff  <= apb_go;
            pslverr_ff <= nxt_pslverr;
            prdata_ff  <= nxt_prdata;
        end
    end

    // outputs
    assign cp_done         = cp_done_ff;
    assign cp_undef        = cp_undef_ff;
    assign cp_rdata        = cp_rdata_ff;
    assign prdata          = prdata_ff;
    assign pready          = pready_ff;
    assign pslverr         = pslverr_ff;
    assign cnt_inc         = inc_ff;
    assign cnt_active      = active_ff;
    // the selection value is passed on unchecked; filter versus event type is
    // the consumer's job and software keeps off the event type at value 31
    assign counter_select  = sel_ff;                                                   // [RULE_14] [RULE_15]
    assign global_count_en = global_ff;

endmodule
`default_nettype wire

// *** hw/pmc_enable_bank.sv ***
// pmc_enable_bank: the three counter enables, written by set-style and clear-style strobes.
// assumes at most one of the set or clear strobes per cycle.
`timescale 1ns/1ps
`default_nettype none
module pmc_enable_bank
(
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // control
    pmc_ctl_if.enb    bus
);
    logic [2:0] en_ff;
    logic [2:0] nxt_en;

    genvar i;
    generate
        for (i = 0; i < 3; i++)
        begin : g_bit
            // ones set or clear, zeros leave the bit alone
            assign nxt_en[i] = (en_ff[i] | (bus.wr_set & bus.wbits[i]))   // [RULE_03]
                               & ~(bus.wr_clr & bus.wbits[i]);            // [RULE_05]
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            en_ff <= pmc_pkg::RST_EN;   // [RULE_23]
        else
            en_ff <= nxt_en;
    end

    assign bus.en_q = en_ff;
endmodule
`default_nettype wire

// *** hw/pmc_ovf_bank.sv ***
// pmc_ovf_bank: sticky overflow flags, cleared by writing ones.
// assumes overflow pulses already gated by the counter's enable.
`timescale 1ns/1ps
`default_nettype none
module pmc_ovf_bank
(
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // control
    pmc_ctl_if.ovf    bus
);
    logic [2:0] ovf_ff;
    logic [2:0] nxt_ovf;

    genvar i;
    generate
        for (i = 0; i < 3; i++)
        begin : g_bit
            // a wrap in the clearing cycle is kept: set beats clear
            assign nxt_ovf[i] = (ovf_ff[i] & ~(bus.wr_ovf_clr & bus.wbits[i]))  // [RULE_10]
                                | bus.ovf_set[i];                               // [RULE_22]
        end
    endgenerate

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ovf_ff <= pmc_pkg::RST_OVF;   // [RULE_23]
        else
            ovf_ff <= nxt_ovf;
    end

    assign bus.ovf_q = ovf_ff;
endmodule
`default_nettype wire

// *** hw/pmc_pkg.sv ***
// pmc_pkg: constants, slot layout and helpers for the performance-monitor control block.
// assumes one processor clock; the counter datapaths sit outside and use the slot order here.
package pmc_pkg;

    // system coprocessor coordinates of the register group
    localparam logic [2:0] CP_OPC1     = 3'h0;
    localparam logic [3:0] CP_CRN      = 4'h9;
    localparam logic [3:0] CP_CRM      = 4'hC;
    localparam logic [2:0] OP2_CTRL    = 3'h0;
    localparam logic [2:0] OP2_EN_SET  = 3'h1;
    localparam logic [2:0] OP2_EN_CLR  = 3'h2;
    localparam logic [2:0] OP2_OVF     = 3'h3;
    localparam logic [2:0] OP2_SWINC   = 3'h4;
    localparam logic [2:0] OP2_SEL     = 3'h5;

    // debug bus byte addresses, bit 12 marks the monitor space
    localparam int unsigned  DBG_ADDR_W  = 13;
    localparam int unsigned  DBG_SPACE   = 12;
    localparam logic [12:0]  APB_EN_SET  = 13'h1C00;
    localparam logic [12:0]  APB_EN_CLR  = 13'h1C20;
    localparam logic [12:0]  APB_OVF     = 13'h1C80;
    localparam logic [12:0]  APB_SWINC   = 13'h1CA0;

    // register decode vector positions
    localparam int unsigned NHIT       = 6;
    localparam int unsigned HIT_CTRL   = 0;
    localparam int unsigned HIT_EN_SET = 1;
    localparam int unsigned HIT_EN_CLR = 2;
    localparam int unsigned HIT_OVF    = 3;
    localparam int unsigned HIT_SWINC  = 4;
    localparam int unsigned HIT_SEL    = 5;

    // counter slots and their bit positions in the 32-bit words
    localparam int unsigned NSLOT      = 3;
    localparam int unsigned SLOT_EV0   = 0;
    localparam int unsigned SLOT_EV1   = 1;
    localparam int unsigned SLOT_CYC   = 2;
    localparam int unsigned BIT_EV0    = 0;
    localparam int unsigned BIT_EV1    = 1;
    localparam int unsigned BIT_CYC    = 31;
    localparam int unsigned CTRL_EN_BIT = 0;

    // selection and event type fields
    localparam int unsigned SEL_W      = 5;
    localparam logic [4:0]  SEL_EV0    = 5'h00;
    localparam logic [4:0]  SEL_EV1    = 5'h01;
    localparam logic [4:0]  SEL_FILTER = 5'h1F;
    localparam int unsigned EVT_W      = 8;
    localparam logic [7:0]  EVT_SWINC  = 8'h00;

    // values after reset
    localparam logic [2:0]  RST_EN     = 3'h0;
    localparam logic [2:0]  RST_OVF    = 3'h0;
    localparam logic        RST_GLOBAL = 1'b0;
    localparam logic [4:0]  RST_SEL    = 5'h00;

    function automatic logic [31:0] pmc_pack(input logic [2:0] s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[BIT_EV0] = s[SLOT_EV0];
        w[BIT_EV1] = s[SLOT_EV1];
        w[BIT_CYC] = s[SLOT_CYC];
        return w;
    endfunction

    function automatic logic [2:0] pmc_unpack(input logic [31:0] w);
        logic [2:0] s;
        s = 3'h0;
        s[SLOT_EV0] = w[BIT_EV0];
        s[SLOT_EV1] = w[BIT_EV1];
        s[SLOT_CYC] = w[BIT_CYC];
        return s;
    endfunction

endpackage

// *** verif/pmc_core_model.sv ***
// pmc_core_model: processor core issuing coprocessor register accesses.
// assumes the bench waits for the answer; requests launch on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module pmc_core_model
(
    // clock
    input wire logic    clk,
    // coprocessor request
    output logic        cp_req,
    output logic        cp_write,
    output logic [2:0]  cp_opc1,
    output logic [3:0]  cp_crn,
    output logic [3:0]  cp_crm,
    output logic [2:0]  cp_opc2,
    output logic [31:0] cp_wdata,
    output logic        cp_priv
);
    // opc1 and crn stay fixed on the owned group; crm comes with each request and may point elsewhere
    assign cp_opc1 = pmc_pkg::CP_OPC1;
    assign cp_crn  = pmc_pkg::CP_CRN;

    initial
    begin
        cp_req = 1'b0;
        cp_write = 1'b0;
        cp_crm = pmc_pkg::CP_CRM;
        cp_opc2 = 3'h0;
        cp_wdata = 32'h5A5A_A5A5;
        cp_priv = 1'b1;
    end

    task automatic issue(input logic w, input logic [2:0] o2, input logic [3:0] crm,
                         input logic [31:0] d, input logic pr);
        @(negedge clk);
        cp_req = 1'b1;
        cp_write = w;
        cp_opc2 = o2;
        cp_crm = crm;
        cp_wdata = d;
        cp_priv = pr;
        @(negedge clk);
        cp_req = 1'b0;
        // stale data would hide a late sample, so it is scrambled at once
        cp_wdata = ~d;
    endtask
endmodule
`default_nettype wire

// *** verif/pmc_ctrl_asserts.sv ***
// pmc_ctrl_asserts: port-level timing checks for the performance-monitor control block.
// assumes it is bound onto pmc_ctrl and sees only that module's ports; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module pmc_ctrl_asserts
(
    // clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    // core port
    input wire logic        cp_req,
    input wire logic        cp_write,
    input wire logic [2:0]  cp_opc2,
    input wire logic        cp_priv,
    input wire logic        user_access_en,
    input wire logic        cp_done,
    input wire logic        cp_undef,
    input wire logic [31:0] cp_rdata,
    // debug port
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    // datapath
    input wire logic [2:0]  cnt_inc,
    input wire logic [2:0]  cnt_active,
    input wire logic        global_count_en
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    a_done_follows: assert property (cp_req |=> cp_done)
        else $error("core access not answered one cycle later");
    a_done_cause: assert property (cp_done |-> $past(cp_req))
        else $error("core answer without a request");
    a_user_refused: assert property (cp_req && !cp_priv && !user_access_en |=> cp_done && cp_undef)
        else $error("unprivileged access accepted without user enable");
    a_rsvd_zero: assert property (cp_done |-> cp_rdata[30:5] == 26'h0)
        else $error("reserved read bits not zero");
    a_undef_zero: assert property (cp_done && cp_undef |-> cp_rdata == 32'h0)
        else $error("refused access returned data");
    a_swinc_rz: assert property (cp_req && !cp_write && cp_opc2 == pmc_pkg::OP2_SWINC
        |=> cp_rdata == 32'h0)
        else $error("software increment read not zero");
    a_active_gated: assert property (cnt_active != 3'h0 |-> $past(global_count_en))
        else $error("counter active while global switch low");
    a_stop_inc: assert property (!global_count_en [*3] |-> cnt_inc == 3'h0)
        else $error("increment while global switch low");
    a_pready_cause: assert property (pready |-> $past(psel) && $past(penable))
        else $error("debug ready without access phase");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("debug ready longer than one cycle");
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// tb: self-checking bench for pmc_ctrl against an integer model of the registers.
// assumes the core model drives the coprocessor port; the bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [3:0]  CM = pmc_pkg::CP_CRM;
    localparam logic [31:0] M  = 32'h8000_0003;
    logic        clk, nrst, cp_req, cp_write, cp_priv, user_access_en, cp_done, cp_undef;
    logic        psel, penable, pwrite, pready, pslverr, global_count_en, un;
    logic [2:0]  cp_opc1, cp_opc2, cnt_wrap, cnt_inc, cnt_active;
    logic [3:0]  cp_crn, cp_crm;
    logic [31:0] cp_wdata, cp_rdata, pwdata, prdata, rd, d, en;
    logic [12:0] debug_bus_address;
    logic [7:0]  evt_type0, evt_type1;
    logic [4:0]  counter_select;
    logic [1:0]  hw_event, seen;
    int          err_count, compares, seed, i;

    pmc_core_model u_core (.clk, .cp_req, .cp_write, .cp_opc1, .cp_crn, .cp_crm, .cp_opc2,
        .cp_wdata, .cp_priv);
    pmc_ctrl u_dut (.clk, .nrst, .cp_req, .cp_write, .cp_opc1, .cp_crn, .cp_crm, .cp_opc2,
        .cp_wdata, .cp_priv, .user_access_en, .cp_done, .cp_undef, .cp_rdata, .psel,
        .penable, .pwrite, .debug_bus_address, .pwdata, .prdata, .pready, .pslverr,
        .evt_type0, .evt_type1, .hw_event, .cnt_wrap, .cnt_inc, .cnt_active,
        .counter_select, .global_count_en);

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) seen <= seen | cnt_inc[1:0];

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp)
            err_count++;
    endtask

    task automatic finish_test();
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cp(input logic w, input logic [2:0] o2, input logic [31:0] wd,
                      input logic [3:0] crm, input logic pr);
        int n;
        u_core.issue(w, o2, crm, wd, pr);
        for (n = 0; n < 4 && cp_done !== 1'b1; n++)
            @(negedge clk);
        if (cp_done !== 1'b1)
        begin
            err_count++;
            finish_test();
        end
        else
        begin
            rd = cp_rdata;
            un = cp_undef;
        end
    endtask

    task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] wd);
        int n;
        @(negedge clk);
        psel = 1'b1;
        pwrite = w;
        debug_bus_address = a;
        pwdata = wd;
        @(negedge clk);
        penable = 1'b1;
        for (n = 0; n < 6 && pready !== 1'b1; n++)
            @(negedge clk);
        if (pready !== 1'b1)
        begin
            err_count++;
            finish_test();
        end
        else
        begin
            un = pslverr;
            rd = prdata;
        end
        @(negedge clk);
        psel = 1'b0;
        penable = 1'b0;
        pwdata = ~wd;
    endtask

    initial
    begin
        {nrst, psel, penable, pwrite, pwdata, debug_bus_address} = '0;
        {hw_event, cnt_wrap, seen, evt_type0, en} = '0;
        user_access_en = 1'b1;
        evt_type1 = 8'h05;
        seed = 47;
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        for (i = 0; i < 6; i++)
        begin
            cp(1'b0, 3'(i), 32'h0, CM, 1'b1);
            chk(rd, 32'h0);
        end
        // random set and clear words, checked through both views
        for (i = 0; i < 8; i++)
        begin
            d = $random(seed);
            cp(1'b1, 3'(1 + i % 2), d, CM, 1'b1);
            en = (i % 2) ? (en & ~(d & M)) : (en | (d & M));
            cp(1'b0, 3'h1, 32'h0, CM, 1'b1);
            chk(rd, en);
            cp(1'b0, 3'h2, 32'h0, CM, 1'b1);
            chk(rd, en);
        end
        cp(1'b1, 3'h1, 32'hFFFF_FFFF, CM, 1'b1);
        cp(1'b1, 3'h0, 32'h1, CM, 1'b1);
        repeat (2) @(negedge clk);
        chk({25'h0, cnt_inc, global_count_en, cnt_active}, 32'h4F);
        cp(1'b1, 3'h0, 32'h0, CM, 1'b1);
        repeat (2) @(negedge clk);
        chk({25'h0, cnt_inc, global_count_en, cnt_active}, 32'h0);
        cp(1'b0, 3'h1, 32'h0, CM, 1'b1);
        chk(rd, M);
        cp(1'b1, 3'h0, 32'h1, CM, 1'b1);
        seen = 2'b00;
        cp(1'b1, 3'h4, 32'h3, CM, 1'b1);
        repeat (3) @(negedge clk);
        chk({30'h0, seen}, 32'h1);
        seen = 2'b00;
        hw_event = 2'b11;
        @(negedge clk);
        hw_event = 2'b00;
        repeat (3) @(negedge clk);
        chk({30'h0, seen}, 32'h2);
        cnt_wrap = 3'h7;
        @(negedge clk);
        cnt_wrap = 3'h0;
        cp(1'b0, 3'h3, 32'h0, CM, 1'b1);
        chk(rd, M);
        cp(1'b1, 3'h3, 32'h7FFF_FFFD, CM, 1'b1);
        cp(1'b0, 3'h3, 32'h0, CM, 1'b1);
        chk(rd, 32'h8000_0002);
        apb(1'b1, pmc_pkg::APB_OVF, 32'h8000_0000);
        chk({31'h0, un}, 32'h0);
        apb(1'b0, pmc_pkg::APB_EN_SET, 32'h0);
        chk(rd, M);
        apb(1'b1, 13'h0C80, 32'h2);
        chk({31'h0, un}, 32'h1);
        cp(1'b0, 3'h3, 32'h0, CM, 1'b1);
        chk(rd, 32'h2);
        cp(1'b1, 3'h5, 32'hFFFF_FFE1, CM, 1'b1);
        chk({27'h0, counter_select}, 32'h1);
        cp(1'b1, 3'h5, 32'h1F, CM, 1'b1);
        cp(1'b0, 3'h5, 32'h0, CM, 1'b1);
        chk(rd, 32'h1F);
        user_access_en = 1'b0;
        cp(1'b0, 3'h1, 32'h0, CM, 1'b0);
        chk({31'h0, un}, 32'h1);
        user_access_en = 1'b1;
        cp(1'b0, 3'h1, 32'h0, CM, 1'b0);
        chk(rd, M);
        cp(1'b0, 3'h1, 32'h0, 4'hD, 1'b1);
        chk({31'h0, un}, 32'h1);
        finish_test();
    end
endmodule

bind pmc_ctrl pmc_ctrl_asserts u_chk (.clk, .nrst, .cp_req, .cp_write, .cp_opc2, .cp_priv,
    .user_access_en, .cp_done, .cp_undef, .cp_rdata, .psel, .penable, .pready, .cnt_inc,
    .cnt_active, .global_count_en);
`default_nettype wire
